// *** include/dcd_pkg.sv ***
// Constants for the serial command decoder
package dcd_pkg;
  localparam int          FRAME_BITS     = 24;
  localparam int          DATA_BITS      = 16;
  localparam int          CNT_W          = 5;
  localparam int          ADDR_MSB       = 19;
  localparam int          ADDR_LSB       = 16;
  localparam int          PRESET_MSB     = 4;
  localparam int          PRESET_LSB     = 3;
  localparam int          RANGE_MSB      = 2;
  localparam int          RANGE_LSB      = 0;
  localparam int          CHAIN_OFF_BIT  = 0;
  localparam logic [4:0]  FRAME_BITS_CNT = 5'h18;
  localparam logic [3:0]  ADDR_NOP0      = 4'h0;
  localparam logic [3:0]  ADDR_WR_INPUT  = 4'h1;
  localparam logic [3:0]  ADDR_UPDATE    = 4'h2;
  localparam logic [3:0]  ADDR_WR_UPDATE = 4'h3;
  localparam logic [3:0]  ADDR_CTRL      = 4'h4;
  localparam logic [3:0]  ADDR_NOP5      = 4'h5;
  localparam logic [3:0]  ADDR_NOP6      = 4'h6;
  localparam logic [3:0]  ADDR_DATA_RST  = 4'h7;
  localparam logic [3:0]  ADDR_CHAIN_OFF = 4'h9;
  localparam logic [3:0]  ADDR_RB_INPUT  = 4'hA;
  localparam logic [3:0]  ADDR_RB_DAC    = 4'hB;
  localparam logic [3:0]  ADDR_NOPD      = 4'hD;
  localparam logic [3:0]  ADDR_NOPE      = 4'hE;
  localparam logic [3:0]  ADDR_FULL_RST  = 4'hF;
  localparam logic [1:0]  PRESET_ZERO    = 2'h0;
  localparam logic [1:0]  PRESET_MID     = 2'h1;
  localparam logic [1:0]  PRESET_FULL    = 2'h2;
  localparam logic [15:0] CODE_ZERO      = 16'h0000;
  localparam logic [15:0] CODE_MID       = 16'h8000;
  localparam logic [15:0] CODE_FULL      = 16'hFFFF;
  localparam logic [2:0]  RANGE_RST      = 3'h0;
  localparam logic        CHAIN_OFF_RST  = 1'b0;
endpackage : dcd_pkg

// *** hw/dcd_frame_shift.sv ***
// Serial pin synchronisers and 24-bit frame shift register
module dcd_frame_shift
  import dcd_pkg::*;
(
  input  wire logic                  mclk,
  input  wire logic                  arst_n,
  input  wire logic                  sclk,
  input  wire logic                  sync_n,
  input  wire logic                  serial_data_input,
  input  wire logic                  load_en,
  input  wire logic [FRAME_BITS-1:0] load_word,
  output logic                       frame_valid,
  output logic [FRAME_BITS-1:0]      frame_word,
  output logic                       shift_out
);
  logic [2:0]            sclk_s;
  logic [2:0]            sync_s;
  logic [1:0]            din_s;
  logic [FRAME_BITS-1:0] sr;
  logic [FRAME_BITS-1:0] next_sr;
  logic [CNT_W-1:0]      cnt;
  logic [CNT_W-1:0]      next_cnt;
  logic                  next_valid;
  logic [FRAME_BITS-1:0] next_word;
  logic                  sclk_fall;
  logic                  sync_rise;

  // Only stages 1 and 2 feed edge detection
  assign sclk_fall = sclk_s[2] & ~sclk_s[1];
  assign sync_rise = ~sync_s[2] & sync_s[1];

  always_comb begin
    next_sr    = sr;
    next_cnt   = cnt;
    next_valid = 1'b0;
    next_word  = frame_word;
    if (load_en) begin
      next_sr = load_word;
    end else if (!sync_s[1] && sclk_fall) begin
      next_sr = {sr[FRAME_BITS-2:0], din_s[1]};
      // Counts one past a full frame so long frames fail the check
      if (cnt <= FRAME_BITS_CNT) begin
        next_cnt = cnt + 5'h01;
      end
    end
    if (sync_rise) begin
      next_cnt = '0;
      // Short or long frames are dropped
      if (cnt == FRAME_BITS_CNT) begin
        next_valid = 1'b1;
        next_word  = sr;
      end
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      sclk_s      <= '0;
      sync_s      <= 3'h7;
      din_s       <= '0;
      sr          <= '0;
      cnt         <= '0;
      frame_valid <= 1'b0;
      frame_word  <= '0;
      shift_out   <= 1'b0;
    end else begin
      sclk_s      <= {sclk_s[1:0], sclk};
      sync_s      <= {sync_s[1:0], sync_n};
      din_s       <= {din_s[0], serial_data_input};
      sr          <= next_sr;
      cnt         <= next_cnt;
      frame_valid <= next_valid;
      frame_word  <= next_word;
      shift_out   <= next_sr[FRAME_BITS-1];
    end
  end
endmodule : dcd_frame_shift

// *** hw/dcd_top.sv ***
// Serial command decoder: daisy-chain disable, data and full resets, no-ops
// Overview of operation
// - Address 1001 loads the daisy-chain disable flag from data bit 0 only.
// - Disable flag resets to 0; writing 1 disables chaining, 0 enables it.
// - Address 0111 sets DAC data to the preset picked by reset_value_select.
// - Address 1111 returns all but the frame shift register to power-up: output grounded, buffer off.
// - A control write that changes range while the buffer is powered performs the full reset.
// - Addresses 0000, 0101, 0110, 1101, 1110 change nothing.
// - With chaining disabled the serial output floats and readbacks are ignored.
// - Each command is 24 bits shifted in most significant bit first.
module dcd_top
  import dcd_pkg::*;
(
  input  wire logic                 mclk,
  input  wire logic                 arst_n,
  input  wire logic                 sclk,
  input  wire logic                 sync_n,
  input  wire logic                 serial_data_input,
  output logic                      serial_data_output,
  output logic                      serial_data_output_oe,
  output logic [DATA_BITS-1:0]      dac_code,
  output logic [2:0]                out_range,
  output logic                      clamp_to_analog_ground,
  output logic                      buffer_powered,
  output logic                      daisy_chain_disable
);
  logic                  frame_valid;
  logic [FRAME_BITS-1:0] frame_word;
  logic                  shift_out;
  logic                  load_en;
  logic [FRAME_BITS-1:0] load_word;
  logic [3:0]            addr;
  logic [DATA_BITS-1:0]  data;
  logic [DATA_BITS-1:0]  input_reg;
  logic [1:0]            reset_value_select;
  logic [DATA_BITS-1:0]  next_input_reg;
  logic [1:0]            next_preset;
  logic [DATA_BITS-1:0]  next_dac_code;
  logic [2:0]            next_range;
  logic                  next_clamp;
  logic                  next_buf;
  logic                  next_chain_off;
  logic                  full_reset;
  logic [DATA_BITS-1:0]  preset_code;

  dcd_frame_shift u_shift (
    .mclk              (mclk),
    .arst_n            (arst_n),
    .sclk              (sclk),
    .sync_n            (sync_n),
    .serial_data_input (serial_data_input),
    .load_en           (load_en),
    .load_word         (load_word),
    .frame_valid       (frame_valid),
    .frame_word        (frame_word),
    .shift_out         (shift_out)
  );

  // Bits 23..20 carry nothing this block uses
  assign addr = frame_word[ADDR_MSB:ADDR_LSB];
  assign data = frame_word[DATA_BITS-1:0];

  always_comb begin
    case (reset_value_select)
      PRESET_MID:  preset_code = CODE_MID;
      PRESET_FULL: preset_code = CODE_FULL;
      default: preset_code = CODE_ZERO;
    endcase
  end

  // Readback reply loaded for the next frame, only while chaining is on
  always_comb begin
    load_en   = 1'b0;
    load_word = '0;
    if (frame_valid && !daisy_chain_disable) begin
      if (addr == ADDR_RB_DAC) begin
        load_en   = 1'b1;
        load_word = {4'h0, ADDR_RB_DAC, dac_code};
      end else if (addr == ADDR_RB_INPUT) begin
        load_en   = 1'b1;
        load_word = {4'h0, ADDR_RB_INPUT, input_reg};
      end
    end
  end

  always_comb begin
    next_input_reg = input_reg;
    next_preset    = reset_value_select;
    next_dac_code  = dac_code;
    next_range     = out_range;
    next_clamp     = clamp_to_analog_ground;
    next_buf       = buffer_powered;
    next_chain_off = daisy_chain_disable;
    full_reset     = 1'b0;
    if (frame_valid) begin
      case (addr)
        ADDR_WR_INPUT: begin
          next_input_reg = data;
        end
        ADDR_UPDATE: begin
          next_dac_code = input_reg;
        end
        ADDR_WR_UPDATE: begin
          next_input_reg = data;
          next_dac_code  = data;
        end
        ADDR_CTRL: begin
          if (buffer_powered && data[RANGE_MSB:RANGE_LSB] != out_range) begin
            full_reset = 1'b1;
          end else begin
            next_preset = data[PRESET_MSB:PRESET_LSB];
            next_range = data[RANGE_MSB:RANGE_LSB];
            next_clamp = 1'b0;
            next_buf   = 1'b1;
          end
        end
        ADDR_DATA_RST: begin
          next_input_reg = preset_code;
          next_dac_code  = preset_code;
        end
        ADDR_CHAIN_OFF: begin
          next_chain_off = data[CHAIN_OFF_BIT];
        end
        ADDR_FULL_RST: begin
          full_reset = 1'b1;
        end
        default: begin
          // No-op addresses and readbacks hold all state
          next_chain_off = daisy_chain_disable;
        end
      endcase
    end
    if (full_reset) begin
      next_input_reg = CODE_ZERO;
      next_dac_code  = CODE_ZERO;
      next_preset    = PRESET_ZERO;
      next_range     = RANGE_RST;
      next_clamp     = 1'b1;
      next_buf       = 1'b0;
      next_chain_off = CHAIN_OFF_RST;
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      input_reg              <= CODE_ZERO;
      reset_value_select     <= PRESET_ZERO;
      dac_code               <= CODE_ZERO;
      out_range              <= RANGE_RST;
      clamp_to_analog_ground <= 1'b1;
      buffer_powered         <= 1'b0;
      daisy_chain_disable    <= CHAIN_OFF_RST;
      serial_data_output     <= 1'b0;
      serial_data_output_oe  <= 1'b0;
    end else begin
      input_reg              <= next_input_reg;
      reset_value_select     <= next_preset;
      dac_code               <= next_dac_code;
      out_range              <= next_range;
      clamp_to_analog_ground <= next_clamp;
      buffer_powered         <= next_buf;
      daisy_chain_disable    <= next_chain_off;
      serial_data_output     <= shift_out & ~next_chain_off;
      serial_data_output_oe  <= ~next_chain_off;
    end
  end

  a_chain_update_bit: assert property (@(posedge mclk) disable iff (!arst_n)
    frame_valid && addr == ADDR_CHAIN_OFF
    |=> daisy_chain_disable == $past(frame_word[CHAIN_OFF_BIT]))
    else $error("disable flag not taken from data bit 0");

  a_chain_full_clear: assert property (@(posedge mclk) disable iff (!arst_n)
    frame_valid && addr == ADDR_FULL_RST |=> !daisy_chain_disable && serial_data_output_oe)
    else $error("full reset did not re-enable chaining");

  a_data_reset_code: assert property (@(posedge mclk) disable iff (!arst_n)
    frame_valid && addr == ADDR_DATA_RST && reset_value_select == PRESET_MID
    |=> dac_code == CODE_MID && $stable(clamp_to_analog_ground))
    else $error("data reset gave wrong code");

  a_full_reset_state: assert property (@(posedge mclk) disable iff (!arst_n)
    frame_valid && addr == ADDR_FULL_RST
    |=> clamp_to_analog_ground && !buffer_powered && dac_code == CODE_ZERO)
    else $error("full reset state wrong");

  a_ctrl_release: assert property (@(posedge mclk) disable iff (!arst_n)
    frame_valid && addr == ADDR_CTRL && !buffer_powered
    |=> !clamp_to_analog_ground && buffer_powered ##1 buffer_powered)
    else $error("control write did not release clamp");

  a_range_change_rst: assert property (@(posedge mclk) disable iff (!arst_n)
    frame_valid && addr == ADDR_CTRL && buffer_powered
    && frame_word[RANGE_MSB:RANGE_LSB] != out_range
    |=> clamp_to_analog_ground && !buffer_powered && out_range == RANGE_RST
    && dac_code == CODE_ZERO)
    else $error("range change did not full reset");

  a_nop_hold_state: assert property (@(posedge mclk) disable iff (!arst_n)
    frame_valid && (addr == ADDR_NOP0 || addr == ADDR_NOP5 || addr == ADDR_NOP6
    || addr == ADDR_NOPD || addr == ADDR_NOPE)
    |=> $stable(dac_code) && $stable(daisy_chain_disable) && $stable(out_range)
    && $stable(clamp_to_analog_ground) && $stable(input_reg))
    else $error("no-op changed state");

  a_dout_tristate: assert property (@(posedge mclk) disable iff (!arst_n)
    daisy_chain_disable |-> !serial_data_output_oe && !load_en)
    else $error("serial output driven while chaining disabled");
endmodule : dcd_top

// *** tb/dcd_host_model.sv ***
// Host serial master model that shifts command frames into the decoder
module dcd_host_model (
  input  wire logic mclk,
  input  wire logic serial_data_output,
  output logic      sclk,
  output logic      sync_n,
  output logic      serial_data_input
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [23:0] rx_word;

  // Idle: clock low and still, frame deselected
  initial begin
    sclk              = 1'b0;
    sync_n            = 1'b1;
    serial_data_input = 1'b0;
    rx_word           = '0;
  end

  // Shift n bits most significant first, data set while the clock is high
  // Returned bit read just before each falling clock edge; extra bits lead as zero
  task automatic send(input logic [23:0] w, input int n);
    @(posedge mclk);
    sync_n <= 1'b0;
    for (int i = n - 1; i >= 0; i--) begin
      repeat (4) @(posedge mclk);
      sclk              <= 1'b1;
      serial_data_input <= (i < 24) ? w[i] : 1'b0;
      repeat (4) @(posedge mclk);
      rx_word <= {rx_word[22:0], serial_data_output};
      sclk    <= 1'b0;
    end
    repeat (4) @(posedge mclk);
    sync_n            <= 1'b1;
    serial_data_input <= ~w[0];
    repeat (10) @(posedge mclk);
    #1;
  endtask : send
endmodule : dcd_host_model

// *** tb/tb.sv ***
// Testbench for the serial command decoder
module tb;
  timeunit 1ns;
  timeprecision 1ps;

  logic             mclk      = 1'b0;
  logic             arst_n    = 1'b0;
  logic             sclk;
  logic             sync_n;
  logic             ser_in;
  logic             ser_out;
  logic             ser_out_oe;
  logic             clamp;
  logic             buf_on;
  logic             chain_off;
  logic [15:0]      dac_code;
  logic [2:0]       out_range;
  wire  logic [6:0] st        = {clamp, buf_on, chain_off, ser_out_oe, out_range};
  // Floating pin read as the inverse of the level behind it
  wire  logic       ser_out_pin = ser_out_oe ? ser_out : ~ser_out;
  logic [15:0]      preset_exp [4] = '{dcd_pkg::CODE_ZERO, dcd_pkg::CODE_MID,
                                       dcd_pkg::CODE_FULL, dcd_pkg::CODE_ZERO};
  logic [3:0]       nop_addr [5] = '{4'h0, 4'h5, 4'h6, 4'hD, 4'hE};
  int               mismatches = 0;
  int               tests_run  = 0;
  int               cycles     = 0;

  always #10 mclk = ~mclk;

  dcd_host_model host (
    .mclk               (mclk),
    .serial_data_output (ser_out_pin),
    .sclk               (sclk),
    .sync_n             (sync_n),
    .serial_data_input  (ser_in)
  );

  dcd_top uut (
    .mclk                   (mclk),
    .arst_n                 (arst_n),
    .sclk                   (sclk),
    .sync_n                 (sync_n),
    .serial_data_input      (ser_in),
    .serial_data_output     (ser_out),
    .serial_data_output_oe  (ser_out_oe),
    .dac_code               (dac_code),
    .out_range              (out_range),
    .clamp_to_analog_ground (clamp),
    .buffer_powered         (buf_on),
    .daisy_chain_disable    (chain_off)
  );

  task automatic check_code(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check_code

  task automatic check_state(input logic [6:0] got, input logic [6:0] exp);
    tests_run++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check_state

  task automatic check_frame(input logic [23:0] got, input logic [23:0] exp);
    tests_run++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check_frame

  task automatic end_of_test();
    if (mismatches == 0 && tests_run > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : end_of_test

  // Cut a hang short
  always @(posedge mclk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      mismatches++;
      end_of_test();
    end
  end

  initial begin
    repeat (20) @(posedge mclk);
    arst_n <= 1'b1;
    repeat (2) @(posedge mclk);
    #1;
    check_code(dac_code, 16'h0000);
    check_state(st, 7'h48);
    host.send(24'h04000B, 24);
    check_state(st, 7'h2B);
    host.send(24'h031234, 24);
    check_code(dac_code, 16'h1234);
    check_frame(host.rx_word, 24'h04000B);
    // Every preset select, then a data reset with junk data bits
    for (int i = 0; i < 4; i++) begin
      host.send({19'h02000, i[1:0], 3'h3}, 24);
      host.send(24'h035A5A, 24);
      host.send(24'hE7FFFF, 24);
      check_code(dac_code, preset_exp[i]);
    end
    host.send(24'h03C3A5, 24);
    foreach (nop_addr[i]) begin
      host.send({4'hE, nop_addr[i], 16'hFFFF}, 24);
      check_code(dac_code, 16'hC3A5);
      check_state(st, 7'h2B);
    end
    host.send(24'h030000, 23);
    check_code(dac_code, 16'hC3A5);
    host.send(24'h03ABCD, 25);
    check_code(dac_code, 16'hC3A5);
    host.send(24'hE9FFFE, 24);
    check_state(st, 7'h2B);
    host.send(24'h090001, 24);
    check_state(st, 7'h33);
    host.send(24'h0A0000, 24);
    check_state(st, 7'h33);
    check_frame(host.rx_word, 24'hFFFFFF);
    host.send(24'h0F0000, 24);
    check_frame(host.rx_word, 24'hFFFFFF);
    check_code(dac_code, 16'h0000);
    check_state(st, 7'h48);
    host.send(24'h04000B, 24);
    check_state(st, 7'h2B);
    check_frame(host.rx_word, 24'h0F0000);
    host.send(24'h090001, 24);
    host.send(24'h090000, 24);
    check_state(st, 7'h2B);
    host.send(24'h031234, 24);
    host.send(24'h0B0000, 24);
    check_frame(host.rx_word, 24'h031234);
    host.send(24'h04000D, 24);
    check_frame(host.rx_word, 24'h0B1234);
    check_code(dac_code, 16'h0000);
    check_state(st, 7'h48);
    host.send(24'h04000D, 24);
    check_state(st, 7'h2D);
    host.send(24'h090001, 24);
    check_state(st, 7'h35);
    // Reset in mid-run with chaining disabled
    @(posedge mclk);
    arst_n <= 1'b0;
    repeat (2) @(posedge mclk);
    arst_n <= 1'b1;
    repeat (2) @(posedge mclk);
    #1;
    check_code(dac_code, 16'h0000);
    check_state(st, 7'h48);
    end_of_test();
  end
endmodule : tb
